// *** core/fifo_flag_defs.svh ***
`ifndef FIFO_FLAG_DEFS_SVH
`define FIFO_FLAG_DEFS_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define REG_AE_OFFSET  8'h00
`define REG_AF_OFFSET  8'h04
`define REG_STATUS     8'h08
`define REG_CTRL       8'h0c
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define OFFSET_DFLT    32'h0000_0007
`define FLAGS_RST      4'ha
`define CTRL_RT_BIT    0
`define ST_EMPTY_BIT   0
`define ST_FULL_BIT    1
`define ST_AE_BIT      2
`define ST_AF_BIT      3
`define ST_BUSY_BIT    4
`define ST_CNT_LSB     8
// ----------------------------------------------------------------
// timing in ns
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  5
`define RT_RECOVERY_NS 90
`define RST_MIN_NS     10
`define RT_PULSE_NS    60
`endif

// *** core/fifo_flag_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package fifo_flag_pkg;
    // retransmit sequencer, gray along idle-reload-settle
    typedef enum logic [1:0] {
        RT_IDLE   = 2'b00,
        RT_RELOAD = 2'b01,
        RT_SETTLE = 2'b11
    } rt_state_t;

    // status flags, all active low
    typedef struct packed {
        logic af_b;
        logic ae_b;
        logic full_b;
        logic empty_b;
    } flags_t;
endpackage
`default_nettype wire

// *** core/dual_clock_fifo_flag_timing.sv ***
// Function
// - full flag release may lag one edge
// - empty flag release may lag one edge
// - reset works with clocks running
// - data outputs low after reset when driven
// - first word follows empty release next cycle
// - extra latency only at empty boundary
// - almost-empty updates on read-side edge
// - almost-full updates on write-side edge
// - almost-empty asserts leaving offset minus one
// - almost-full asserts at capacity minus offset plus one
// - flags valid after retransmit recovery time
// - partial flags need one more cycle
// - empty offset defaults to seven
// - full offset defaults to seven
//
// The register addresses and strobed register access were decided locally.
`include "fifo_flag_defs.svh"
`default_nettype none

module dual_clock_fifo_flag_timing
    import fifo_flag_pkg::*;
#(
    parameter int DATA_W = 9,
    parameter int ADDR_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              wr_en,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              out_ready,
    output logic                   out_valid,
    output logic      [DATA_W-1:0] out_data,
    output logic                   out_oe,
    input  wire logic              oe_b,
    input  wire logic              rt_b,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   empty_flag_b,
    output logic                   full_flag_b,
    output logic                   almost_empty_flag_b,
    output logic                   almost_full_flag_b
);
    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int RT_CYC =
        (`RT_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int RT_MAX = RT_CYC + 2;
    localparam logic [ADDR_W:0] DEPTH_C = {1'b1, {ADDR_W{1'b0}}};
    localparam logic [ADDR_W:0] ONE_C   = {{ADDR_W{1'b0}}, 1'b1};
    localparam logic [4:0]      RT_LOAD = 5'(RT_CYC);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [ADDR_W:0]   wptr_ff;
    logic [ADDR_W:0]   rptr_ff;
    logic [ADDR_W-1:0] ae_off_ff;
    logic [ADDR_W-1:0] af_off_ff;
    logic [DATA_W-1:0] head_ff;
    logic              head_v_ff;
    logic [DATA_W-1:0] tail_ff;
    logic              tail_v_ff;
    flags_t            flags_ff;
    rt_state_t         rt_state_ff;
    logic [4:0]        rt_cnt_ff;
    logic              oe_s1_ff;
    logic              oe_s2_ff;
    logic              rt_s1_ff;
    logic              rt_s2_ff;
    logic              rt_s3_ff;
    logic              oe_drv_ff;
    logic [31:0]       rdata_ff;
    logic              cfg_ae_wr_ff;
    logic              cfg_af_wr_ff;

    // ------------------------------------------------------------
    // decode and selection
    // ------------------------------------------------------------
    logic              wr_acc;
    logic              pop;
    logic              fetch;
    logic              rt_req;
    logic              rt_reload;
    logic [ADDR_W:0]   mem_cnt;
    logic [ADDR_W+1:0] tot_cnt;
    logic [ADDR_W:0]   nxt_wptr;
    logic [ADDR_W:0]   nxt_rptr;
    logic [ADDR_W:0]   nxt_mem_cnt;
    logic [ADDR_W+1:0] nxt_tot_cnt;
    logic [ADDR_W:0]   af_thresh;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] nxt_head;
    logic              nxt_head_v;
    logic [DATA_W-1:0] nxt_tail;
    logic              nxt_tail_v;
    flags_t            nxt_flags;
    rt_state_t         nxt_rt_state;
    logic [4:0]        nxt_rt_cnt;
    logic [31:0]       nxt_rdata;
    logic [31:0]       status_word;
    logic              sel_ae;
    logic              sel_af;
    logic              sel_st;
    logic              sel_ctrl;

    // register address decode
    assign sel_ae   = (reg_addr == `REG_AE_OFFSET);
    assign sel_af   = (reg_addr == `REG_AF_OFFSET);
    assign sel_st   = (reg_addr == `REG_STATUS);
    assign sel_ctrl = (reg_addr == `REG_CTRL);

    // retransmit from pin falling edge or control write
    assign rt_req    = (rt_s3_ff & ~rt_s2_ff)
                     | (reg_wr & sel_ctrl & reg_wdata[`CTRL_RT_BIT]);
    assign rt_reload = (rt_state_ff == RT_RELOAD);

    // accepted write and read, blocked at the flag boundaries
    assign wr_acc = wr_en & flags_ff.full_b;
    assign pop    = head_v_ff & out_ready;
    assign mem_cnt = wptr_ff - rptr_ff;
    assign tot_cnt = {1'b0, mem_cnt}
                   + {{(ADDR_W+1){1'b0}}, head_v_ff}
                   + {{(ADDR_W+1){1'b0}}, tail_v_ff};

    // fetch into the two-entry buffer; stalled while it is full
    assign fetch = (mem_cnt != '0) & ~tail_v_ff
                 & (rt_state_ff == RT_IDLE);
    assign mem_q = mem[rptr_ff[ADDR_W-1:0]];

    // pointer next values, read side reloads on retransmit
    assign nxt_wptr = wr_acc ? (wptr_ff + ONE_C) : wptr_ff;
    assign nxt_rptr = rt_reload ? '0
                    : (fetch ? (rptr_ff + ONE_C) : rptr_ff);

    // buffer head is loaded first, tail only behind a held head
    assign nxt_head_v = rt_reload ? 1'b0
                      : (pop | ~head_v_ff) ? (tail_v_ff | fetch)
                      : 1'b1;
    assign nxt_head   = rt_reload ? '0
                      : ~(pop | ~head_v_ff) ? head_ff
                      : tail_v_ff ? tail_ff
                      : fetch ? mem_q : '0;
    assign nxt_tail_v = ~rt_reload & ~pop & head_v_ff
                      & (tail_v_ff | fetch);
    assign nxt_tail   = (~pop & head_v_ff & fetch) ? mem_q : tail_ff;

    // flags from the counts that the coming edge leaves behind
    assign nxt_mem_cnt = nxt_wptr - nxt_rptr;
    assign nxt_tot_cnt = {1'b0, nxt_mem_cnt}
                       + {{(ADDR_W+1){1'b0}}, nxt_head_v}
                       + {{(ADDR_W+1){1'b0}}, nxt_tail_v};
    assign af_thresh   = DEPTH_C - {1'b0, af_off_ff} + ONE_C;
    assign nxt_flags.empty_b = (nxt_tot_cnt != '0);
    assign nxt_flags.full_b  = (nxt_mem_cnt != DEPTH_C);
    assign nxt_flags.ae_b    =
        (nxt_tot_cnt >= {2'b00, ae_off_ff});
    assign nxt_flags.af_b    = (nxt_mem_cnt < af_thresh);

    // retransmit sequencer: reload, then wait out recovery time
    assign nxt_rt_state =
        (rt_state_ff == RT_IDLE)   ? (rt_req ? RT_RELOAD : RT_IDLE)
      : (rt_state_ff == RT_RELOAD) ? RT_SETTLE
      : (rt_cnt_ff == 5'h00)       ? RT_IDLE
      : RT_SETTLE;
    assign nxt_rt_cnt =
        rt_reload ? RT_LOAD
      : (rt_cnt_ff != 5'h00) ? (rt_cnt_ff - 5'h01) : 5'h00;

    // read data mux, unmapped addresses read zero
    assign status_word = {
        {(32-`ST_CNT_LSB-ADDR_W-2){1'b0}}, tot_cnt,
        3'b000, (rt_state_ff != RT_IDLE),
        flags_ff.af_b, flags_ff.ae_b, flags_ff.full_b, flags_ff.empty_b};
    assign nxt_rdata =
        ~reg_rd  ? 32'h0000_0000
      : sel_ae   ? {{(32-ADDR_W){1'b0}}, ae_off_ff}
      : sel_af   ? {{(32-ADDR_W){1'b0}}, af_off_ff}
      : sel_st   ? status_word
      : 32'h0000_0000;

    // ------------------------------------------------------------
    // storage array, data only, no reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (wr_acc) begin
            mem[wptr_ff[ADDR_W-1:0]] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            oe_s1_ff <= 1'b1;
            oe_s2_ff <= 1'b1;
            rt_s1_ff <= 1'b1;
            rt_s2_ff <= 1'b1;
            rt_s3_ff <= 1'b1;
        end else begin
            oe_s1_ff <= oe_b;
            oe_s2_ff <= oe_s1_ff;
            rt_s1_ff <= rt_b;
            rt_s2_ff <= rt_s1_ff;
            rt_s3_ff <= rt_s2_ff;
        end
    end

    // ------------------------------------------------------------
    // pointers, buffer and flags; reset needs no stopped clock
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wptr_ff   <= '0;
            rptr_ff   <= '0;
            head_ff   <= '0;
            head_v_ff <= 1'b0;
            tail_ff   <= '0;
            tail_v_ff <= 1'b0;
            flags_ff  <= `FLAGS_RST;
            oe_drv_ff <= 1'b0;
        end else begin
            wptr_ff   <= nxt_wptr;
            rptr_ff   <= nxt_rptr;
            head_ff   <= nxt_head;
            head_v_ff <= nxt_head_v;
            tail_ff   <= nxt_tail;
            tail_v_ff <= nxt_tail_v;
            flags_ff  <= nxt_flags;
            oe_drv_ff <= ~oe_s2_ff;
        end
    end

    // ------------------------------------------------------------
    // retransmit sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rt_state_ff <= RT_IDLE;
            rt_cnt_ff   <= 5'h00;
        end else begin
            rt_state_ff <= nxt_rt_state;
            rt_cnt_ff   <= nxt_rt_cnt;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ae_off_ff    <= ADDR_W'(`OFFSET_DFLT);
            af_off_ff    <= ADDR_W'(`OFFSET_DFLT);
            cfg_ae_wr_ff <= 1'b0;
            cfg_af_wr_ff <= 1'b0;
            rdata_ff     <= 32'h0000_0000;
        end else begin
            if (reg_wr && sel_ae) begin
                ae_off_ff    <= reg_wdata[ADDR_W-1:0];
                cfg_ae_wr_ff <= 1'b1;
            end
            if (reg_wr && sel_af) begin
                af_off_ff    <= reg_wdata[ADDR_W-1:0];
                cfg_af_wr_ff <= 1'b1;
            end
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs, each a flop
    assign out_valid           = head_v_ff;
    assign out_data            = head_ff;
    assign out_oe              = oe_drv_ff;
    assign reg_rdata           = rdata_ff;
    assign empty_flag_b        = flags_ff.empty_b;
    assign full_flag_b         = flags_ff.full_b;
    assign almost_empty_flag_b = flags_ff.ae_b;
    assign almost_full_flag_b  = flags_ff.af_b;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_rt_start;
        rt_state_ff == RT_RELOAD;
    endsequence
    sequence s_rt_done;
        rt_state_ff == RT_IDLE;
    endsequence

    a_full_blocks_write: assert property (
        (!full_flag_b && wr_en) |=> (wptr_ff == $past(wptr_ff)))
        else $error("write taken while full");
    a_empty_no_data: assert property (
        !empty_flag_b |-> !out_valid)
        else $error("data offered while empty");
    a_first_word_next: assert property (
        ($rose(empty_flag_b) && rt_state_ff == RT_IDLE) |=> out_valid)
        else $error("first word late after empty release");
    a_full_release: assert property (
        (!full_flag_b && out_ready && out_valid) |-> ##[1:3] full_flag_b)
        else $error("full flag stuck after read");
    a_empty_release: assert property (
        (!empty_flag_b && wr_en && full_flag_b) |=> empty_flag_b)
        else $error("empty flag stuck after write");
    a_idle_out_low: assert property (
        !out_valid |-> (out_data == '0))
        else $error("data outputs not low while idle");
    a_ae_threshold: assert property (
        $fell(almost_empty_flag_b) |->
            (tot_cnt == {2'b00, ae_off_ff} - 1) || $past(rt_reload)
            || $past(reg_wr))
        else $error("almost empty asserted at wrong fill");
    a_af_threshold: assert property (
        $fell(almost_full_flag_b) |->
            (mem_cnt == af_thresh) || $past(reg_wr))
        else $error("almost full asserted at wrong fill");
    a_rt_recovery: assert property (
        s_rt_start |-> !fetch [*2] ##[1:RT_MAX] s_rt_done)
        else $error("retransmit recovery not bounded");
    a_rt_pointer_zero: assert property (
        s_rt_start |=> (rptr_ff == '0) && !out_valid)
        else $error("read pointer not reloaded");
    a_ae_default: assert property (
        !cfg_ae_wr_ff |-> (ae_off_ff == ADDR_W'(`OFFSET_DFLT)))
        else $error("empty offset not default");
    a_af_default: assert property (
        !cfg_af_wr_ff |-> (af_off_ff == ADDR_W'(`OFFSET_DFLT)))
        else $error("full offset not default");
    a_flags_settle: assert property (
        (($past(rt_state_ff) == RT_SETTLE) ##0 s_rt_done) |=>
            (almost_empty_flag_b == (tot_cnt >= {2'b00, ae_off_ff}))
            && (almost_full_flag_b == (mem_cnt < af_thresh)))
        else $error("partial flag not updated after recovery");

endmodule // dual_clock_fifo_flag_timing
`default_nettype wire

// *** tb/fifo_consumer_model.sv ***
`default_nettype none
// ----------------------------------------------------------------
// read-side consumer, stalls at random unless held off
// ----------------------------------------------------------------
module fifo_consumer_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       hold,
    input  wire logic       out_valid,
    input  wire logic [8:0] out_data,
    output logic            out_ready,
    output logic            took_ff,
    output logic [8:0]      took_data_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    // ready drops one edge after hold, so callers wait before relying on it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_ready    <= 1'b0;
            took_ff      <= 1'b0;
            took_data_ff <= 9'h000;
        end else begin
            out_ready    <= !hold && ($urandom % 4 != 0);
            took_ff      <= out_valid && out_ready;
            took_data_ff <= out_data;
        end
    end
endmodule // fifo_consumer_model
`default_nettype wire

// *** tb/test_dual_clock_fifo_flag_timing.sv ***
`default_nettype none
module test_dual_clock_fifo_flag_timing;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 16;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        wr_en = 1'b0;
    logic [8:0]  wr_data = 9'h000;
    logic        oe_b = 1'b0;
    logic        rt_b = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        hold = 1'b1;
    logic        out_ready, out_valid, out_oe, took_ff;
    logic [8:0]  out_data, took_data_ff;
    logic [31:0] reg_rdata, d;
    logic        empty_flag_b, full_flag_b;
    logic        almost_empty_flag_b, almost_full_flag_b;
    wire  [31:0] flags_w;
    logic [8:0]  exp_q[$];
    logic [8:0]  sent_q[$];
    int          miscompares = 0;
    int          compares = 0;
    int          cnt = 0;
    int          n = 7;
    int          m = 7;

    assign flags_w = {28'h0, almost_full_flag_b, almost_empty_flag_b,
                      full_flag_b, empty_flag_b};

    // ----------------------------------------------------------------
    // clock, design and consumer
    // ----------------------------------------------------------------
    always #2.5 clk_sys = ~clk_sys;

    dual_clock_fifo_flag_timing #(.DATA_W(9), .ADDR_W(4))
        dual_clock_fifo_flag_timing_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .wr_en(wr_en),
        .wr_data(wr_data), .out_ready(out_ready), .out_valid(out_valid),
        .out_data(out_data), .out_oe(out_oe), .oe_b(oe_b), .rt_b(rt_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .empty_flag_b(empty_flag_b), .full_flag_b(full_flag_b),
        .almost_empty_flag_b(almost_empty_flag_b),
        .almost_full_flag_b(almost_full_flag_b));

    fifo_consumer_model fifo_consumer_model_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .hold(hold),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .took_ff(took_ff), .took_data_ff(took_data_ff));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // flags from total count; a stalled buffer holds two words
    function automatic logic [31:0] flags_for(int c, int ne, int mf);
        int mem;
        mem = (c > 2) ? c - 2 : 0;
        return {28'h0, mem < DEPTH - mf + 1, c >= ne, mem < DEPTH, c > 0};
    endfunction

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // back-to-back writes with the consumer held off
    task automatic push_words(input int k);
        for (int i = 0; i <= k; i++) begin
            @(posedge clk_sys);
            if (wr_en && full_flag_b) begin
                sent_q.push_back(wr_data);
                exp_q.push_back(wr_data);
                cnt++;
            end
            wr_en   <= (i < k);
            wr_data <= 9'($urandom);
            #1 check(flags_w, flags_for(cnt, n, m));
        end
    endtask

    task automatic drain();
        hold <= 1'b0;
        for (int t = 0;
             t < 400 && (exp_q.size() != 0 || empty_flag_b !== 1'b0); t++)
            @(posedge clk_sys);
        hold <= 1'b1;
        cnt = 0;
        check(exp_q.size(), 0);
        #1 check(flags_w, flags_for(0, n, m));
    endtask

    // popped words in write order
    always @(posedge clk_sys) begin
        if (took_ff) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check(took_data_ff, exp_q.pop_front());
        end
    end

    initial begin
        #100000;
        miscompares++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(68));
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 check(flags_w, flags_for(0, 7, 7));
        check(out_valid, 1'b0);
        repeat (4) @(posedge clk_sys);
        #1 check({out_oe, out_data}, 10'h200);
        reg_read(8'h10, d);
        check(d, 32'h0);
        oe_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 check(out_oe, 1'b0);
        oe_b <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                n = 1 + $urandom % 8;
                m = 1 + $urandom % 8;
                reg_write(8'h00, n);
                reg_write(8'h04, m);
            end
            reg_read(8'h00, d);
            check(d, n);
            reg_read(8'h04, d);
            check(d, m);
            push_words(1);
            check(out_valid, 1'b0);
            @(posedge clk_sys);
            #1 check({out_valid, out_data}, {1'b1, sent_q[$]});
            push_words(19);
            check(cnt, 18);
            reg_read(8'h08, d);
            check(d, (cnt << 8) | flags_for(cnt, n, m));
            drain();
        end
        // reset in mid-run with the clock still running
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 check(flags_w, flags_for(0, 7, 7));
        @(posedge clk_sys);
        rst_b <= 1'b1;
        n = 7;
        m = 7;
        sent_q.delete();
        push_words(10);
        drain();
        // replay by register, then by pin
        for (int r = 0; r < 2; r++) begin
            exp_q = sent_q;
            if (r == 0) reg_write(8'h0c, 32'h1);
            else begin
                @(posedge clk_sys);
                rt_b <= 1'b0;
                repeat (12) @(posedge clk_sys);
                rt_b <= 1'b1;
            end
            reg_read(8'h08, d);
            check(d[4], 1'b1);
            repeat (24) @(posedge clk_sys);
            reg_read(8'h08, d);
            check(d, (10 << 8) | flags_for(10, 7, 7));
            drain();
        end
        end_sim();
    end
endmodule // test_dual_clock_fifo_flag_timing
`default_nettype wire
